// ===== rtl/cac_counter_control.sv
// Function
// (R01) overflow flag sets when counter wraps
// (R02) flags cleared only by software writes
// (R03) overflow enable masks overflow flag request
// (R04) counter advances only while run set
// (R05) module event flags set on match/capture only while run set and not idle-suspended
// (R06) enabled module flag raises shared request
// (R07) idle suspend bit stops array during idle
// (R08) pulse select chooses count timebase
// (R09) count falling edges on external input
// (R10) external clock divided eight, synchronised
// (R11) cycle overflow flag at selected bit
// (R12) cycle overflow enable masks its request
// (R13) cycle length select sets pwm length
// (R14) reload select steers compare accesses
// (R15) reserved bits read zero, ignore writes
`default_nettype none
module cac_counter_control
    import cac_pkg::*;
(
    input  wire logic        core_clk,      // system clock
    input  wire logic        rst_n,         // async reset
    input  wire cac_sfr_s    sfr,           // register access
    output logic      [7:0]  sfr_rdata,     // read data
    input  wire logic        cpu_idle,      // processor in idle
    input  wire logic        timer0_ovf,    // timer 0 overflow pulse
    input  wire logic        external_count_input, // count pin
    input  wire logic        ext_clk,       // external clock level
    input  wire logic        lfo_clk,       // low-freq osc level
    input  wire logic  [2:0] module_event,  // match/capture pulses
    input  wire logic  [2:0] module_irq_en, // per-module enables
    output logic      [15:0] main_counter,  // counter value
    output logic             count_tick,    // counter advanced
    output logic             counter_array_irq, // interrupt request
    output logic       [2:0] cycle_length_select, // pwm length
    output logic             reload_select  // compare steering
);
    logic [7:0] ctrl, mode, pwm;
    logic [7:0] next_ctrl, next_mode, next_pwm;
    logic [15:0] next_counter;
    logic [3:0] div_cnt, next_div_cnt;
    logic [2:0] ext_div, next_ext_div, lfo_div, next_lfo_div;
    logic ecn_d, ext_s1, ext_s2, ext_s3, lfo_s1, lfo_s2, lfo_s3;
    logic next_tick, next_irq, tick, active, wrap, cyc_ovf;
    logic [7:0] next_rdata;
    int cyc_bit;

    // rising edge of a level already taken through two flops
    function automatic logic rise(input logic prev, input logic cur);
        return cur & ~prev;
    endfunction

    assign active = ctrl[CAC_BIT_RUN] &
                    ~(mode[CAC_BIT_IDLE] & cpu_idle); // see (R04) (R07)

    always_comb begin
        next_div_cnt = div_cnt + 4'(1);
        if (div_cnt == 4'(CAC_DIV12 - 1))
            next_div_cnt = '0;
        next_ext_div = ext_div;
        next_lfo_div = lfo_div;
        // three-bit edge count wraps by itself after eight edges
        if (rise(ext_s3, ext_s2))
            next_ext_div = ext_div + 3'(1); // see (R10)
        if (rise(lfo_s3, lfo_s2))
            next_lfo_div = lfo_div + 3'(1);
        unique case (cac_ps_e'(mode[CAC_BIT_PS_LO +: 3])) // see (R08)
            CAC_PS_DIV12:  tick = (div_cnt == 4'(CAC_DIV12 - 1));
            CAC_PS_DIV4:   tick = (div_cnt[1:0] == 2'(CAC_DIV4 - 1));
            CAC_PS_T0OVF:  tick = timer0_ovf;
            CAC_PS_EXTIN:  tick = ecn_d & ~external_count_input; // see (R09)
            CAC_PS_SYSCLK: tick = 1'b1;
            CAC_PS_EXTCLK: tick = rise(ext_s3, ext_s2) &
                                  (ext_div == 3'(CAC_DIV8 - 1)); // see (R10)
            CAC_PS_LFO:    tick = rise(lfo_s3, lfo_s2) &
                                  (lfo_div == 3'(CAC_DIV8 - 1));
            CAC_PS_RSVD:   tick = 1'b0;
        endcase
        tick = tick & active;
        next_tick = tick;
        next_counter = tick ? main_counter + 16'(1) : main_counter;
        wrap = tick & (main_counter == CAC_CNT_MAX); // see (R01)
        cyc_bit = CAC_CLK_BASE - 1 + int'(pwm[2:0]); // see (R13)
        if (pwm[2:0] > 3'(3))
            cyc_bit = CAC_CLK_BASE - 1;
        cyc_ovf = tick & (main_counter[cyc_bit[3:0] +: 1] == 1'b1) &
                  (next_counter[cyc_bit[3:0] +: 1] == 1'b0); // see (R11)

        next_ctrl = ctrl;
        next_mode = mode;
        next_pwm  = pwm;
        if (sfr.wr) begin // see (R15) (R02)
            unique case (sfr.addr)
                CAC_ADDR_CTRL: next_ctrl = sfr.wdata & CAC_MASK_CTRL;
                CAC_ADDR_MODE: next_mode = sfr.wdata & CAC_MASK_MODE;
                CAC_ADDR_PWM:  next_pwm  = sfr.wdata & CAC_MASK_PWM;
                default: ;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        if (wrap)
            next_ctrl[CAC_BIT_OVF] = 1'b1; // see (R01)
        if (active)
            next_ctrl[2:0] = next_ctrl[2:0] | module_event; // see (R05)
        if (cyc_ovf)
            next_pwm[CAC_BIT_CYCLE_OVERFLOW_FLAG] = 1'b1; // see (R11)

        next_irq = (next_ctrl[CAC_BIT_OVF] & next_mode[CAC_BIT_OVF_IE]) | // see (R03)
                   |(next_ctrl[2:0] & module_irq_en) |            // see (R06)
                   (next_pwm[CAC_BIT_CYCLE_OVERFLOW_FLAG] & next_pwm[CAC_BIT_COV_IE]); // see (R12)
        unique case (sfr.addr)
            CAC_ADDR_CTRL: next_rdata = ctrl;
            CAC_ADDR_MODE: next_rdata = mode;
            CAC_ADDR_PWM:  next_rdata = pwm;
            default:       next_rdata = CAC_RESET;
        endcase
        if (!sfr.rd)
            next_rdata = sfr_rdata;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CAC_RESET;
            mode <= CAC_RESET;
            pwm <= CAC_RESET;
            main_counter <= '0;
            div_cnt <= '0;
            ext_div <= '0;
            lfo_div <= '0;
            ecn_d <= 1'b1;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            lfo_s1 <= 1'b0;
            lfo_s2 <= 1'b0;
            lfo_s3 <= 1'b0;
            count_tick <= 1'b0;
            counter_array_irq <= 1'b0;
            sfr_rdata <= CAC_RESET;
            cycle_length_select <= '0;
            reload_select <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            mode <= next_mode;
            pwm <= next_pwm;
            main_counter <= next_counter;
            div_cnt <= next_div_cnt;
            ext_div <= next_ext_div;
            lfo_div <= next_lfo_div;
            ecn_d <= external_count_input;
            ext_s1 <= ext_clk;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            lfo_s1 <= lfo_clk;
            lfo_s2 <= lfo_s1;
            lfo_s3 <= lfo_s2;
            count_tick <= next_tick;
            counter_array_irq <= next_irq;
            sfr_rdata <= next_rdata;
            cycle_length_select <= next_pwm[2:0]; // see (R13)
            reload_select <= next_pwm[CAC_BIT_RSEL]; // see (R14)
        end
    end

    property p_wrap_sets_flag; // see (R01)
        @(posedge core_clk) disable iff (!rst_n)
        wrap |=> ctrl[CAC_BIT_OVF];
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag) // see (R01)
        else $error("overflow flag not set on wrap");

    property p_flag_sticky; // see (R02)
        @(posedge core_clk) disable iff (!rst_n)
        ctrl[CAC_BIT_OVF] && !(sfr.wr && sfr.addr == CAC_ADDR_CTRL)
        |=> ctrl[CAC_BIT_OVF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // see (R02)
        else $error("overflow flag cleared by hardware");

    property p_ovf_irq; // see (R03)
        @(posedge core_clk) disable iff (!rst_n)
        ctrl[CAC_BIT_OVF] && mode[CAC_BIT_OVF_IE] |-> counter_array_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) // see (R03)
        else $error("overflow request missing");

    property p_hold; // see (R04)
        @(posedge core_clk) disable iff (!rst_n)
        !ctrl[CAC_BIT_RUN] |=> $stable(main_counter);
    endproperty
    a_hold: assert property (p_hold) // see (R04)
        else $error("counter moved while stopped");

    property p_idle; // see (R07)
        @(posedge core_clk) disable iff (!rst_n)
        mode[CAC_BIT_IDLE] && cpu_idle |=> $stable(main_counter);
    endproperty
    a_idle: assert property (p_idle) // see (R07)
        else $error("counter moved in idle suspend");

    property p_sysclk; // see (R08)
        @(posedge core_clk) disable iff (!rst_n)
        active && mode[CAC_BIT_PS_LO +: 3] == 3'(CAC_PS_SYSCLK) && !(sfr.wr)
        |=> main_counter == $past(main_counter) + 16'(1);
    endproperty
    a_sysclk: assert property (p_sysclk) // see (R08)
        else $error("system clock source failed to count");

    property p_mod_irq; // see (R06)
        @(posedge core_clk) disable iff (!rst_n)
        |(ctrl[2:0] & $past(module_irq_en)) |-> counter_array_irq;
    endproperty
    a_mod_irq: assert property (p_mod_irq) // see (R06)
        else $error("module request missing");

    property p_cov_irq; // see (R12)
        @(posedge core_clk) disable iff (!rst_n)
        counter_array_irq |-> (ctrl[CAC_BIT_OVF] & mode[CAC_BIT_OVF_IE]) |
            |(ctrl[2:0] & $past(module_irq_en)) |
            (pwm[CAC_BIT_CYCLE_OVERFLOW_FLAG] & pwm[CAC_BIT_COV_IE]) |
            |(ctrl[2:0] & module_irq_en);
    endproperty
    a_cov_irq: assert property (p_cov_irq) // see (R12)
        else $error("request without enabled flag");
endmodule
`default_nettype wire

// ===== rtl/cac_pkg.sv
`default_nettype none
package cac_pkg;
    localparam logic [7:0] CAC_ADDR_CTRL = 8'hD8;
    localparam logic [7:0] CAC_ADDR_MODE = 8'hD9;
    localparam logic [7:0] CAC_ADDR_PWM  = 8'hF7;
    localparam int CAC_BIT_OVF    = 7;
    localparam int CAC_BIT_RUN    = 6;
    localparam int CAC_BIT_IDLE   = 7;
    localparam int CAC_BIT_PS_LO  = 1;
    localparam int CAC_BIT_OVF_IE = 0;
    localparam int CAC_BIT_RSEL   = 7;
    localparam int CAC_BIT_COV_IE = 6;
    localparam int CAC_BIT_CYCLE_OVERFLOW_FLAG   = 5;
    localparam logic [7:0] CAC_MASK_CTRL = 8'hC7;
    localparam logic [7:0] CAC_MASK_MODE = 8'h8F;
    localparam logic [7:0] CAC_MASK_PWM  = 8'hE7;
    localparam logic [7:0] CAC_RESET     = 8'h00;
    localparam logic [15:0] CAC_CNT_MAX  = 16'hFFFF;
    localparam int CAC_DIV12 = 12;
    localparam int CAC_DIV4  = 4;
    localparam int CAC_DIV8  = 8;
    localparam int CAC_CLK_BASE = 8;
    typedef enum logic [2:0] {
        CAC_PS_DIV12, CAC_PS_DIV4, CAC_PS_T0OVF, CAC_PS_EXTIN,
        CAC_PS_SYSCLK, CAC_PS_EXTCLK, CAC_PS_LFO, CAC_PS_RSVD
    } cac_ps_e;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cac_sfr_s;
endpackage
`default_nettype wire

// ===== testbench/cac_counter_control_tb.sv
`default_nettype none
module cac_counter_control_tb
    import cac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk;
    logic        rst_n;
    cac_sfr_s    sfr;
    logic [7:0]  sfr_rdata;
    logic        cpu_idle;
    logic        timer0_ovf;
    logic        external_count_input;
    logic        ext_clk;
    logic        lfo_clk;
    logic [2:0]  module_event;
    logic [2:0]  module_irq_en;
    logic [15:0] main_counter;
    logic [15:0] c0;
    logic        count_tick;
    logic        counter_array_irq;
    logic [2:0]  cycle_length_select;
    logic        reload_select;
    int          mismatches;
    int          tests_run;

    cac_counter_control uut (
        .core_clk            (core_clk),
        .rst_n               (rst_n),
        .sfr                 (sfr),
        .sfr_rdata           (sfr_rdata),
        .cpu_idle            (cpu_idle),
        .timer0_ovf          (timer0_ovf),
        .external_count_input(external_count_input),
        .ext_clk             (ext_clk),
        .lfo_clk             (lfo_clk),
        .module_event        (module_event),
        .module_irq_en       (module_irq_en),
        .main_counter        (main_counter),
        .count_tick          (count_tick),
        .counter_array_irq   (counter_array_irq),
        .cycle_length_select (cycle_length_select),
        .reload_select       (reload_select)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // all drives land 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // strobe dropped for a cycle so it never toggles twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        tick(1);
        sfr.wr = 1'b0;
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr.addr = a;
        sfr.rd = 1'b1;
        tick(1);
        sfr.rd = 1'b0;
        tick(1);
        chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
    endtask

    task automatic irq(input logic e);
        tick(3);
        chk("counter_array_irq", {15'h0000, e}, {15'h0000, counter_array_irq});
    endtask

    // windows on divided sources are whole periods, so counts are exact
    task automatic src(input logic idl, input logic [2:0] ps, input int n,
                       input logic [15:0] e);
        wr(CAC_ADDR_MODE, {idl, 3'h0, ps, 1'b0});
        tick(4);
        c0 = main_counter;
        for (int i = 0; i < n; i++) begin
            case (ps)
                3'h2: timer0_ovf = 1'b1;
                3'h3: external_count_input = 1'b1;
                3'h5: ext_clk = 1'b1;
                3'h6: lfo_clk = 1'b1;
                default: ;
            endcase
            tick(ps inside {3'h3, 3'h5, 3'h6} ? 4 : 1);
            timer0_ovf = 1'b0;
            external_count_input = 1'b0;
            ext_clk = 1'b0;
            lfo_clk = 1'b0;
            if (ps inside {3'h2, 3'h3, 3'h5, 3'h6}) begin
                tick(4);
            end
        end
        if (ps inside {3'h2, 3'h3, 3'h5, 3'h6}) begin
            tick(6);
        end
        chk("main_counter", e, main_counter - c0);
        if (ps == 3'h4) begin
            chk("count_tick", 16'(e != 0), 16'(count_tick));
        end
    endtask

    initial begin
        rst_n = 1'b0;
        sfr = '0;
        cpu_idle = 1'b0;
        timer0_ovf = 1'b0;
        external_count_input = 1'b0;
        ext_clk = 1'b0;
        lfo_clk = 1'b0;
        module_event = 3'h0;
        module_irq_en = 3'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(1);
        rd(CAC_ADDR_CTRL, 8'h00);
        rd(CAC_ADDR_MODE, 8'h00);
        rd(CAC_ADDR_PWM, 8'h00);
        rd(8'h55, 8'h00);
        wr(CAC_ADDR_MODE, 8'hFF);
        rd(CAC_ADDR_MODE, 8'h8F);
        wr(CAC_ADDR_PWM, 8'hFF);
        rd(CAC_ADDR_PWM, 8'hE7);
        chk("reload_select", 16'h0001, {15'h0000, reload_select});
        chk("cycle_length", 16'h0007, {13'h0000, cycle_length_select});
        wr(CAC_ADDR_CTRL, 8'hFF);
        rd(CAC_ADDR_CTRL, 8'hC7);
        irq(1'b1);
        wr(CAC_ADDR_CTRL, 8'h00);
        wr(CAC_ADDR_MODE, 8'h00);
        wr(CAC_ADDR_PWM, 8'h00);
        irq(1'b0);
        $display("test registers done");
        src(1'b0, 3'h4, 10, 16'h0000);
        wr(CAC_ADDR_CTRL, 8'h40);
        src(1'b0, 3'h4, 10, 16'h000A);
        src(1'b0, 3'h1, 48, 16'h000C);
        src(1'b0, 3'h0, 96, 16'h0008);
        src(1'b0, 3'h2, 5, 16'h0005);
        src(1'b0, 3'h3, 5, 16'h0005);
        src(1'b0, 3'h5, 16, 16'h0002);
        src(1'b0, 3'h6, 16, 16'h0002);
        cpu_idle = 1'b1;
        src(1'b1, 3'h4, 10, 16'h0000);
        src(1'b0, 3'h4, 10, 16'h000A);
        cpu_idle = 1'b0;
        $display("test sources done");
        for (int i = 0; i <= 70000 && main_counter !== 16'hFFFF; i++) begin
            tick(1);
        end
        chk("main_counter", 16'hFFFF, main_counter);
        tick(3);
        rd(CAC_ADDR_CTRL, 8'hC0);
        rd(CAC_ADDR_PWM, 8'h20);
        wr(CAC_ADDR_CTRL, 8'h80);
        tick(20);
        rd(CAC_ADDR_CTRL, 8'h80);
        irq(1'b0);
        wr(CAC_ADDR_MODE, 8'h09);
        irq(1'b1);
        wr(CAC_ADDR_CTRL, 8'h00);
        irq(1'b0);
        wr(CAC_ADDR_PWM, 8'h60);
        irq(1'b1);
        wr(CAC_ADDR_PWM, 8'h00);
        irq(1'b0);
        wr(CAC_ADDR_MODE, 8'h00);
        $display("test overflow done");
        wr(CAC_ADDR_CTRL, 8'h40);
        module_event = 3'h5;
        tick(1);
        module_event = 3'h0;
        tick(2);
        rd(CAC_ADDR_CTRL, 8'h45);
        module_irq_en = 3'h2;
        irq(1'b0);
        module_irq_en = 3'h4;
        irq(1'b1);
        wr(CAC_ADDR_CTRL, 8'h40);
        irq(1'b0);
        $display("test module flags done");
        finish_test();
    end
endmodule
`default_nettype wire
